//--- rtl/asr_host.sv
/*
 * host-side controller for a 64K x 16 asynchronous sram: takes one read or
 * write request at a time and plays it out on the memory pins with cycle
 * counts. assumes the memory's data pins are joined to data_out/data_oe_out
 * and data_in by the surrounding logic; data_in is asynchronous.
 */
`timescale 1ns/1ns
module asr_host
    import asr_pkg::*;
(
    input  wire logic              clk_in,          // 100 MHz clock
    input  wire logic              nrst_in,         // async reset, active low
    input  wire logic              req_in,          // request strobe
    input  wire logic              we_in,           // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] addr_in,         // word address
    input  wire logic [DATA_W-1:0] wdata_in,        // write data
    input  wire logic [1:0]        lane_en_in,      // bit1 high lane, bit0 low lane
    output logic                   ready_out,       // request accepted when high
    output logic [DATA_W-1:0]      rdata_out,       // read data
    output logic                   rvalid_out,      // read data strobe
    output logic [ADDR_W-1:0]      addr_out,        // memory address pins
    output logic                   chip_sel_n_out,  // chip select, low active
    output logic                   write_en_n_out,  // write enable, low active
    output logic                   drive_en_n_out,  // output enable, low active
    output logic                   upper_lane_en_n_out, // high lane enable, low active
    output logic                   lower_lane_en_n_out, // low lane enable, low active
    output logic [DATA_W-1:0]      data_out,        // data pins, host drive value
    output logic                   data_oe_out,     // host drives data pins when high
    input  wire logic [DATA_W-1:0] data_in          // data pins, level seen
);

    asr_state_e         state;
    asr_state_e         next_state;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   next_cnt;
    logic [DATA_W-1:0]  sync1;
    logic [DATA_W-1:0]  sync2;
    logic [1:0]         lanes;
    logic               next_ready;
    logic               next_rvalid;
    logic               next_cs_n;
    logic               next_we_n;
    logic               next_oe_n;
    logic [1:0]         next_lane_n;
    logic               next_data_oe;
    logic               latch_req;

    wire  logic         take      = req_in & ready_out;
    wire  logic         cnt_done  = (cnt == CNT_ZERO);
    wire  logic [1:0]   req_lanes = (lane_en_in == LANES_NONE) ? LANES_BOTH : lane_en_in;
    wire  logic         latch_rd  = (state == ASR_READ) & cnt_done;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt - CNT_W'(1);
        next_cs_n    = 1'b1;
        next_we_n    = 1'b1;
        next_oe_n    = 1'b1;
        next_lane_n  = LANES_BOTH;
        next_data_oe = 1'b0;
        next_rvalid  = 1'b0;
        latch_req    = 1'b0;
        case (state)
            ASR_IDLE: begin
                next_cnt = CNT_ZERO;
                if (take && we_in) begin
                    // address, select, lanes and write enable start together
                    next_state   = ASR_WRITE;
                    next_cnt     = WRITE_LOAD;
                    latch_req    = 1'b1;
                    next_cs_n    = 1'b0;
                    next_we_n    = 1'b0;
                    next_lane_n  = ~req_lanes;
                    next_data_oe = 1'b1;                   // output enable stays high
                end else if (take) begin
                    next_state   = ASR_READ;
                    next_cnt     = READ_LOAD;
                    latch_req    = 1'b1;
                    next_cs_n    = 1'b0;
                    next_oe_n    = 1'b0;
                    next_lane_n  = ~req_lanes;
                end
            end
            ASR_READ: begin
                // pins held for full access time plus synchroniser delay
                if (cnt_done) begin
                    next_state  = ASR_TURN;
                    next_cnt    = TURN_LOAD;
                    next_rvalid = 1'b1;
                end else begin
                    next_cs_n   = 1'b0;
                    next_oe_n   = 1'b0;
                    next_lane_n = ~lanes;
                end
            end
            ASR_TURN: begin
                // wait out memory driver release before anyone drives
                if (cnt_done) begin
                    next_state = ASR_IDLE;
                end
            end
            ASR_WRITE: begin
                // pulse of whole cycles covers width, select and setup minima
                if (cnt_done) begin
                    // all enables rise on one edge, so that edge ends the write
                    next_state   = ASR_RECOVER;
                    next_cnt     = REC_LOAD;
                    next_data_oe = 1'b1;                   // data held past the end
                end else begin
                    next_cs_n    = 1'b0;
                    next_we_n    = 1'b0;
                    next_lane_n  = ~lanes;
                    next_data_oe = 1'b1;
                end
            end
            ASR_RECOVER: begin
                // address held after the end and cycle padded to write period
                if (cnt_done) begin
                    next_state = ASR_IDLE;
                end else begin
                    next_data_oe = 1'b1;
                end
            end
            default: begin
                next_state = ASR_IDLE;
                next_cnt   = CNT_ZERO;
            end
        endcase
        next_ready = (next_state == ASR_IDLE);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state      <= ASR_IDLE;
            cnt        <= CNT_ZERO;
            ready_out  <= 1'b0;
            rvalid_out <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            ready_out  <= next_ready;
            rvalid_out <= next_rvalid;
        end
    end

    // deselected in idle puts the memory in standby
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            chip_sel_n_out      <= 1'b1;
            write_en_n_out      <= 1'b1;
            drive_en_n_out      <= 1'b1;
            upper_lane_en_n_out <= 1'b1;
            lower_lane_en_n_out <= 1'b1;
            data_oe_out         <= 1'b0;
        end else begin
            chip_sel_n_out      <= next_cs_n;
            write_en_n_out      <= next_we_n;
            drive_en_n_out      <= next_oe_n;
            upper_lane_en_n_out <= next_lane_n[1];
            lower_lane_en_n_out <= next_lane_n[0];
            data_oe_out         <= next_data_oe;
        end
    end

    // address and write data change only when a request is taken
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_out <= '0;
            data_out <= '0;
            lanes    <= LANES_NONE;
        end else if (latch_req) begin
            addr_out <= addr_in;
            data_out <= wdata_in;
            lanes    <= req_lanes;
        end
    end

    // data pins are asynchronous to clk_in
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= data_in;
            sync2 <= sync1;
        end
    end

    // disabled lanes read back as zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= '0;
        end else if (latch_rd) begin
            rdata_out <= {lanes[1] ? sync2[DATA_W-1:LANE_W] : {LANE_W{1'b0}},
                          lanes[0] ? sync2[LANE_W-1:0]      : {LANE_W{1'b0}}};
        end
    end

endmodule : asr_host

//--- rtl/asr_pkg.sv
/*
 * constants, pin-timing figures and cycle counts for the asynchronous sram
 * host controller. assumes a single 100 MHz clock and a 64K x 16 memory.
 */
package asr_pkg;

    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 16;
    localparam int LANE_W       = 8;
    localparam int CNT_W        = 8;
    localparam int SYNC_STAGES  = 2;

    localparam int CLK_PERIOD_NS = 10;

    localparam int READ_PERIOD_MIN_NS      = 70;
    localparam int ADDR_ACCESS_TIME_NS     = 70;
    localparam int SELECT_ACCESS_TIME_NS   = 70;
    localparam int DRIVE_EN_ACCESS_TIME_NS = 35;
    localparam int LANE_EN_ACCESS_TIME_NS  = 35;
    localparam int DRIVER_OFF_MAX_NS       = 25;
    localparam int WRITE_RELEASE_TIME_NS   = 25;
    localparam int WRITE_PERIOD_MIN_NS     = 70;
    localparam int WRITE_PULSE_MIN_NS      = 60;
    localparam int LANE_PULSE_MIN_NS       = 60;
    localparam int SELECT_TO_END_MIN_NS    = 60;
    localparam int ADDR_TO_END_MIN_NS      = 60;
    localparam int WRITE_DATA_SETUP_NS     = 35;

    // least times round up to whole cycles, never below one
    function automatic int cyc_up(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    localparam int READ_ACCESS_CYC = max2(max2(cyc_up(ADDR_ACCESS_TIME_NS),
        cyc_up(SELECT_ACCESS_TIME_NS)), max2(max2(cyc_up(DRIVE_EN_ACCESS_TIME_NS),
        cyc_up(LANE_EN_ACCESS_TIME_NS)), cyc_up(READ_PERIOD_MIN_NS)));
    localparam int READ_HOLD_CYC   = READ_ACCESS_CYC + SYNC_STAGES;
    localparam int TURN_CYC        = max2(cyc_up(DRIVER_OFF_MAX_NS),
                                          cyc_up(WRITE_RELEASE_TIME_NS));
    localparam int WRITE_PULSE_CYC = max2(max2(cyc_up(WRITE_PULSE_MIN_NS),
        cyc_up(LANE_PULSE_MIN_NS)), max2(max2(cyc_up(SELECT_TO_END_MIN_NS),
        cyc_up(ADDR_TO_END_MIN_NS)), cyc_up(WRITE_DATA_SETUP_NS)));
    localparam int WRITE_REC_CYC   = max2(cyc_up(WRITE_PERIOD_MIN_NS) - WRITE_PULSE_CYC, 1);

    localparam logic [CNT_W-1:0] READ_LOAD  = CNT_W'(READ_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] TURN_LOAD  = CNT_W'(TURN_CYC - 1);
    localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] REC_LOAD   = CNT_W'(WRITE_REC_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_BOTH = 2'h3;

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_READ,
        ASR_TURN,
        ASR_WRITE,
        ASR_RECOVER
    } asr_state_e;

endpackage : asr_pkg

//--- testbench/asr_host_monitor.sv
/* pin protocol checker for asr_host, bound to every instance.
   assumes the single clk_in domain and sees only the controller's ports. */
`timescale 1ns/1ns
module asr_host_monitor
    import asr_pkg::*;
(
    input wire logic              clk_in,              // clock
    input wire logic              nrst_in,             // reset, low
    input wire logic              req_in,              // request
    input wire logic              we_in,               // write select
    input wire logic [1:0]        lane_en_in,          // lanes asked
    input wire logic              ready_out,           // idle
    input wire logic              rvalid_out,          // read strobe
    input wire logic [ADDR_W-1:0] addr_out,            // address pins
    input wire logic              chip_sel_n_out,      // select
    input wire logic              write_en_n_out,      // write enable
    input wire logic              drive_en_n_out,      // output enable
    input wire logic              upper_lane_en_n_out, // high lane
    input wire logic              lower_lane_en_n_out, // low lane
    input wire logic [DATA_W-1:0] data_out,            // drive value
    input wire logic              data_oe_out          // host drives
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire       take_rd   = req_in && ready_out && !we_in;
    wire       take_wr   = req_in && ready_out && we_in;
    wire [1:0] lanes_req = (lane_en_in == LANES_NONE) ? LANES_BOTH : lane_en_in;
    sequence s_rd_on;
        (!chip_sel_n_out && !drive_en_n_out && write_en_n_out && !rvalid_out)[*8];
    endsequence
    sequence s_wr_on;
        (!chip_sel_n_out && !write_en_n_out && drive_en_n_out && data_oe_out)[*6];
    endsequence
    read_access_a: assert property (take_rd |=> s_rd_on ##1 !chip_sel_n_out ##1
        (chip_sel_n_out && drive_en_n_out && rvalid_out)) else $error("read pin order wrong");
    rvalid_pulse_a: assert property (rvalid_out |=> !rvalid_out)
        else $error("read strobe too long");
    write_pulse_a: assert property (take_wr |=> s_wr_on ##1
        (write_en_n_out && chip_sel_n_out && upper_lane_en_n_out && lower_lane_en_n_out &&
        data_oe_out) ##1 !data_oe_out) else $error("write pin order wrong");
    read_turn_a: assert property (take_rd |=> !ready_out[*8] ##1
        !ready_out[*4] ##1 ready_out) else $error("read turnaround wrong");
    write_period_a: assert property (take_wr |=> !ready_out[*7] ##1 ready_out)
        else $error("write period wrong");
    addr_hold_a: assert property ($past(!chip_sel_n_out) |-> $stable(addr_out))
        else $error("address moved while selected");
    data_hold_a: assert property ($past(!write_en_n_out) |->
        $stable(data_out) && data_oe_out) else $error("write data moved");
    no_clash_a: assert property (data_oe_out |-> drive_en_n_out)
        else $error("host drives with output enabled");
    idle_standby_a: assert property (ready_out |->
        chip_sel_n_out && write_en_n_out && !data_oe_out) else $error("idle pins not in standby");
    lane_pick_a: assert property (req_in && ready_out |=>
        {upper_lane_en_n_out, lower_lane_en_n_out} == ~$past(lanes_req))
        else $error("lane pins wrong");
endmodule : asr_host_monitor

bind asr_host asr_host_monitor i_asr_host_monitor (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(req_in), .we_in(we_in), .lane_en_in(lane_en_in), .ready_out(ready_out),
    .rvalid_out(rvalid_out), .addr_out(addr_out), .chip_sel_n_out(chip_sel_n_out),
    .write_en_n_out(write_en_n_out), .drive_en_n_out(drive_en_n_out),
    .upper_lane_en_n_out(upper_lane_en_n_out), .lower_lane_en_n_out(lower_lane_en_n_out),
    .data_out(data_out), .data_oe_out(data_oe_out));

//--- testbench/asr_sram_model.sv
/* behavioural 64K x 16 asynchronous memory behind asr_host.
   assumes the bench resolves the data wire from q_out and lane_drv_out. */
`timescale 1ns/1ns
module asr_sram_model
    import asr_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr_in,            // address pins
    input  wire logic              chip_sel_n_in,      // select
    input  wire logic              write_en_n_in,      // write enable
    input  wire logic              drive_en_n_in,      // output enable
    input  wire logic              upper_lane_en_n_in, // high lane
    input  wire logic              lower_lane_en_n_in, // low lane
    input  wire logic [DATA_W-1:0] data_in,            // wire level
    input  wire logic [7:0]        acc_ns_in,          // access time
    output logic      [DATA_W-1:0] q_out,              // drive value
    output logic      [1:0]        lane_drv_out        // lanes driven
);
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] w_data;
    logic [ADDR_W-1:0] w_addr;
    logic [1:0]        w_lanes;
    time               t_chg;
    wire [1:0] lanes = ~{upper_lane_en_n_in, lower_lane_en_n_in};
    wire rd = !chip_sel_n_in && write_en_n_in && !drive_en_n_in;
    wire wr = !chip_sel_n_in && !write_en_n_in && (lanes != 2'h0);
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        q_out = 16'h0000;
        t_chg = 0;
    end
    always @(rd, addr_in, lanes) t_chg = $time;
    always @* if (wr) begin
        w_data = data_in;
        w_addr = addr_in;
        w_lanes = lanes;
    end
    // store when the first enable lets go
    always @(negedge wr) begin
        if (w_lanes[0] === 1'h1) mem[w_addr][7:0] = w_data[7:0];
        if (w_lanes[1] === 1'h1) mem[w_addr][15:8] = w_data[15:8];
    end
    always #1 begin
        lane_drv_out <= (rd && $time - t_chg >= 10) ? lanes : 2'h0;
        q_out <= ($time - t_chg >= acc_ns_in) ? mem[addr_in] :
                 ($time - t_chg < 10) ? q_out : ~q_out;
    end
endmodule : asr_sram_model

//--- testbench/test_asr_host.sv
/* self-checking bench for asr_host driving a behavioural memory.
   assumes asr_sram_model and the bound checker are compiled with it. */
`timescale 1ns/1ns
module test_asr_host
    import asr_pkg::*;
;
    logic              clk_in, nrst_in, req_in, we_in, ready_out, rvalid_out, data_oe_out;
    logic              cs_n, we_n, oe_n, ub_n, lb_n;
    logic [ADDR_W-1:0] addr_in, addr_out, a;
    logic [DATA_W-1:0] wdata_in, rdata_out, data_out, dq, m_q, noise, d;
    logic [1:0]        lane_en_in, m_drv;
    logic [7:0]        acc_ns;
    logic [DATA_W-1:0] shadow [0:65535];
    logic [DATA_W-1:0] expq [$];
    int                bad_count, n_tests, cyc;
    asr_host i_asr_host (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in), .we_in(we_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .lane_en_in(lane_en_in), .ready_out(ready_out),
        .rdata_out(rdata_out), .rvalid_out(rvalid_out), .addr_out(addr_out),
        .chip_sel_n_out(cs_n), .write_en_n_out(we_n), .drive_en_n_out(oe_n),
        .upper_lane_en_n_out(ub_n), .lower_lane_en_n_out(lb_n), .data_out(data_out),
        .data_oe_out(data_oe_out), .data_in(dq));
    asr_sram_model i_asr_sram_model (.addr_in(addr_out), .chip_sel_n_in(cs_n),
        .write_en_n_in(we_n), .drive_en_n_in(oe_n), .upper_lane_en_n_in(ub_n),
        .lower_lane_en_n_in(lb_n), .data_in(dq), .acc_ns_in(acc_ns), .q_out(m_q),
        .lane_drv_out(m_drv));
    // undriven lanes carry a pattern that moves every cycle
    assign dq = data_oe_out ? data_out : {m_drv[1] ? m_q[15:8] : noise[15:8],
                                          m_drv[0] ? m_q[7:0] : noise[7:0]};
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    // one request on the command port; notes the expected read word
    task automatic op(input logic w, input logic [1:0] l);
        int          n;
        logic [15:0] m;
        n = 0;
        m = {{8{l[1] | ~|l}}, {8{l[0] | ~|l}}};
        @(posedge clk_in);
        req_in <= 1'h1;
        we_in <= w;
        addr_in <= a;
        wdata_in <= d;
        lane_en_in <= l;
        do @(posedge clk_in); while (ready_out !== 1'h1 && ++n < 40);
        req_in <= 1'h0;
        if (n >= 40) check(16'h0001, 16'h0000);
        if (!w) expq.push_back(shadow[a] & m);
        else shadow[a] = (shadow[a] & ~m) | (d & m);
    endtask : op
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        noise <= noise + 16'h9e37;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end
    always @(negedge clk_in) if (rvalid_out === 1'h1) begin
        if (expq.size() == 0) check(16'h0001, 16'h0000);
        else check(rdata_out, expq.pop_front());
    end
    initial begin
        {nrst_in, req_in, we_in, addr_in, wdata_in, lane_en_in, a, d, noise} = '0;
        acc_ns = 8'h14;
        cyc = 0;
        bad_count = 0;
        n_tests = 0;
        foreach (shadow[i]) shadow[i] = 16'h0000;
        void'($urandom(64377));
        repeat (19) @(posedge clk_in);
        @(negedge clk_in);
        check({8'h00, ready_out, rvalid_out, cs_n, we_n, oe_n, ub_n, lb_n,
               data_oe_out}, 16'h003e);
        check(addr_out | data_out | rdata_out, 16'h0000);
        @(posedge clk_in);
        nrst_in <= 1'h1;
        // prompt memory first, then one near its slowest access
        for (int k = 0; k < 48; k++) begin
            acc_ns <= (k < 24) ? 8'h14 : 8'h41;
            a = (k % 5 == 0) ? 16'hffff : 16'($urandom % 4);
            d = 16'($urandom);
            op(1'($urandom), 2'(k));
        end
        // a write offered while a read is busy must be ignored
        a = 16'h0005;
        op(1'h0, 2'h3);
        @(posedge clk_in);
        req_in <= 1'h1;
        we_in <= 1'h1;
        wdata_in <= 16'h5a5a;
        repeat (3) @(posedge clk_in);
        req_in <= 1'h0;
        op(1'h0, 2'h0);
        repeat (20) @(posedge clk_in);
        check(16'(expq.size()), 16'h0000);
        results();
    end
endmodule : test_asr_host
